//--- plf_pkg.sv
/*
 * constants shared by the phase limit / switching frequency register slice:
 * register offsets, field positions, reset values and timing counts.
 * assumes the second-function latch bytes come from a neighbouring block.
 */
package plf_pkg;
    // register offsets on the serial interface
    localparam logic [7:0] ADDR_LIMIT_FLAGS  = 8'h2d;
    localparam logic [7:0] ADDR_LIMIT_CFG    = 8'h2e;
    localparam logic [7:0] ADDR_FREQ_STRAP   = 8'h2f;
    localparam logic [7:0] ADDR_FREQ_CFG     = 8'h30;

    // field layout
    localparam int         CODE_W            = 5;   // code field bits 4:0
    localparam int         PHASES            = 8;   // bit 7 phase eight .. bit 0 phase one
    localparam int         PHASE_CNT_W       = 4;
    localparam int         KHZ_W             = 13;
    localparam int         MV_W              = 11;

    // selection bit positions inside both latch bytes
    localparam int         SEL_FREQ_BIT      = 0;
    localparam int         SEL_LIMIT_BIT     = 2;

    // reset values
    localparam logic [4:0] LIMIT_CFG_RST     = 5'h00;
    localparam logic [4:0] FREQ_CFG_RST      = 5'h00;
    localparam logic [4:0] FREQ_STRAP_RST    = 5'h00;

    // threshold mapping: 0.2 V base, 0.05 V per code
    localparam int         LIMIT_BASE_MV     = 200;
    localparam int         LIMIT_STEP_MV     = 50;

    // serial interface
    localparam logic [6:0] DEV_ADDR_DEFAULT  = 7'h40;  // arbitrary value
    localparam int         SYNC_W            = 24;      // scl, sda, straps, flags, phases
    localparam logic [23:0] SYNC_RST         = 24'hc00000;

    // settle time before the one-shot strap capture
    localparam int         STRAP_SETTLE_NS   = 15;
    localparam int         CLK_PERIOD_NS     = 5;
    localparam logic [1:0] STRAP_SETTLE_CYC  =
        2'((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

//--- plf_freq_table.sv
/*
 * frequency lookup: frequency code and active phase count to kHz.
 * assumes phase count 1..8 on the same clock; other counts read as eight.
 */
`timescale 1ns/1ps
module plf_freq_table
(
    input  wire logic                           clk,      // system clock
    input  wire logic                           rst_n,    // synchronised reset
    input  wire logic [plf_pkg::CODE_W-1:0]     code,     // active frequency code
    input  wire logic [plf_pkg::PHASE_CNT_W-1:0] phases,  // active phase count
    output logic      [plf_pkg::KHZ_W-1:0]      khz_reg   // switching frequency
);
    import plf_pkg::*;

    // one row per code, columns eight phases down to one phase, values as printed
    localparam logic [12:0] FREQ_KHZ [256] = '{
        221, 253, 295, 355, 221, 293, 223, 232,
        244, 276, 330, 399, 244, 329, 243, 252,
        266, 309, 355, 425, 266, 358, 264, 272,
        293, 327, 387, 460, 293, 381, 294, 297,
        307, 351, 412, 501, 307, 407, 317, 322,
        333, 384, 441, 542, 333, 450, 335, 340,
        351, 409, 480, 561, 351, 480, 352, 361,
        373, 431, 499, 615, 373, 510, 380, 385,
        394, 451, 528, 639, 394, 530, 399, 413,
        421, 481, 559, 676, 421, 562, 420, 435,
        449, 495, 593, 725, 449, 600, 436, 456,
        469, 525, 612, 746, 469, 614, 454, 478,
        479, 563, 639, 757, 479, 631, 483, 500,
        509, 570, 681, 799, 509, 663, 508, 509,
        518, 588, 697, 831, 518, 688, 526, 518,
        543, 617, 722, 874, 543, 722, 543, 540,
        581, 665, 779, 930, 581, 789, 583, 578,
        649, 718, 881, 1043, 649, 859, 656, 638,
        708, 790, 937, 1129, 708, 930, 698, 698,
        751, 868, 1010, 1211, 751, 1010, 771, 758,
        799, 918, 1073, 1278, 799, 1095, 807, 818,
        866, 1003, 1136, 1372, 866, 1147, 860, 878,
        919, 1025, 1220, 1449, 919, 1233, 899, 938,
        964, 1111, 1297, 1533, 964, 1260, 950, 972,
        993, 1140, 1339, 6716, 993, 1341, 1003, 1014,
        1059, 1198, 1438, 1687, 1059, 1372, 1052, 1067,
        1098, 1262, 1485, 1734, 1098, 1450, 1096, 1106,
        1141, 1295, 1533, 1821, 1141, 1539, 1154, 1155,
        1200, 1338, 1587, 7530, 1200, 1619, 1205, 1201,
        1236, 1405, 1608, 1954, 1236, 1618, 1227, 1245,
        1291, 1459, 1707, 2012, 1291, 1674, 1274, 1280,
        1312, 1493, 1724, 2096, 1312, 1724, 1316, 1330
    };

    logic [2:0] col;

    // out-of-range phase counts fall back to the full eight-phase column
    always_comb
    begin
        if (phases >= 4'd1 && phases <= 4'd8)
            col = 3'(4'd8 - phases);
        else
            col = 3'd0;
    end

    // registered read keeps the output glitch free
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            khz_reg <= 13'h0000;
        else
            khz_reg <= FREQ_KHZ[{code, col}];
    end
endmodule

//--- plf_regs.sv
/*
 * register slice for per-phase current limit and switching frequency select,
 * reached through a small serial (two-wire) target. assumes the strap codes
 * are quasi-static digitised resistor readings, phase limit flags come from
 * the analog comparators, and the two latch bytes come from the same clock.
 */
`timescale 1ns/1ps
module plf_regs
#(
    parameter logic [6:0] DEV_ADDR = plf_pkg::DEV_ADDR_DEFAULT
)
(
    input  wire logic                             clk,               // 200 MHz clock
    input  wire logic                             rstn,              // async reset, low
    input  wire logic                             scl_i,             // serial clock pin
    input  wire logic                             sda_i,             // serial data pin in
    output logic                                  sda_o,             // serial data out
    output logic                                  sda_oe_n,          // low while pulling sda
    input  wire logic [plf_pkg::CODE_W-1:0]       limit_strap_code,  // limit resistor code
    input  wire logic [plf_pkg::CODE_W-1:0]       freq_strap_code,   // frequency resistor code
    input  wire logic [plf_pkg::PHASES-1:0]       phase_limit_hit,   // per-phase limit active
    input  wire logic [plf_pkg::PHASE_CNT_W-1:0]  active_phases,     // phases in use
    input  wire logic [7:0]                       sel_latch_a,       // latch byte a
    input  wire logic [7:0]                       sel_latch_b,       // latch byte b
    output logic      [plf_pkg::CODE_W-1:0]       limit_code_active, // threshold code in force
    output logic      [plf_pkg::MV_W-1:0]         limit_thresh_mv,   // threshold in mV
    output logic      [plf_pkg::CODE_W-1:0]       freq_code_active,  // frequency code in force
    output logic      [plf_pkg::KHZ_W-1:0]        freq_khz           // switching frequency
);
    import plf_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
        ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
    } plf_i2c_t;

    logic [1:0]        rst_pipe_reg;
    logic              rst_n;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic              scl_s;
    logic              sda_s;
    logic              scl_d_reg;
    logic              sda_d_reg;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;
    logic [4:0]        limit_strap_s;
    logic [4:0]        freq_strap_s;
    logic [7:0]        limit_flags;
    logic [3:0]        phases_s;
    plf_i2c_t          state_reg;
    logic [3:0]        bit_cnt_reg;
    logic [7:0]        shift_reg;
    logic [7:0]        tx_reg;
    logic [7:0]        ptr_reg;
    logic              rw_reg;
    logic              ack_ok_reg;
    logic              oe_n_reg;
    logic              wr_hit;
    logic [4:0]        limit_cfg_reg;
    logic [4:0]        freq_cfg_reg;
    logic [4:0]        freq_strap_reg;
    logic [1:0]        cap_cnt_reg;
    logic              cap_done_reg;
    logic              limit_sel;
    logic              freq_sel;
    logic [4:0]        limit_code_next;
    logic [4:0]        freq_code_next;

    // reset released through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_pipe_reg <= 2'b00;
        else
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
    assign rst_n = rst_pipe_reg[1];

    // two-flop sync of every pin except the latch bytes; multi-bit straps are quasi-static so skew is harmless
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end
        else
        begin
            sync1_reg <= {scl_i, sda_i, limit_strap_code, freq_strap_code,
                          phase_limit_hit, active_phases};
            sync2_reg <= sync1_reg;
        end
    end
    assign scl_s         = sync2_reg[23];
    assign sda_s         = sync2_reg[22];
    assign limit_strap_s = sync2_reg[21:17];
    assign freq_strap_s  = sync2_reg[16:12];
    assign limit_flags   = sync2_reg[11:4];
    assign phases_s      = sync2_reg[3:0];

    // bus line history for edge and start/stop detection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // readback; unmapped offsets read zero
    function automatic logic [7:0] rd_byte(input logic [7:0] addr);
        case (addr)
            ADDR_LIMIT_FLAGS: rd_byte = limit_flags;
            ADDR_LIMIT_CFG:   rd_byte = {3'b000, limit_sel ? limit_cfg_reg
                                                           : limit_strap_s};
            ADDR_FREQ_STRAP:  rd_byte = {3'b000, freq_strap_reg};
            ADDR_FREQ_CFG:    rd_byte = {3'b000, freq_cfg_reg};
            default:          rd_byte = 8'h00;
        endcase
    endfunction

    // serial target: address, register pointer, then data with auto-increment
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            rw_reg      <= 1'b0;
            ack_ok_reg  <= 1'b0;
            oe_n_reg    <= 1'b1;
        end
        else if (start_cond)
        begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            oe_n_reg    <= 1'b1;
        end
        else if (stop_cond)
        begin
            state_reg <= ST_IDLE;
            oe_n_reg  <= 1'b1;
        end
        else if (scl_rise)
        begin
            if (state_reg == ST_ADDR || state_reg == ST_REG || state_reg == ST_WDATA)
            begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (state_reg == ST_RACK)
                ack_ok_reg <= ~sda_s;
        end
        else if (scl_fall)
        begin
            case (state_reg)
                ST_ADDR:
                    if (bit_cnt_reg == 4'h8)
                    begin
                        if (shift_reg[7:1] == DEV_ADDR)
                        begin
                            rw_reg    <= shift_reg[0];
                            oe_n_reg  <= 1'b0;
                            state_reg <= ST_ACK_ADDR;
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                ST_ACK_ADDR:
                begin
                    bit_cnt_reg <= 4'h0;
                    if (rw_reg)
                    begin
                        tx_reg    <= rd_byte(ptr_reg);
                        oe_n_reg  <= rd_byte(ptr_reg) >> 7 == 8'h01 ? 1'b1 : 1'b0;
                        state_reg <= ST_RDATA;
                    end
                    else
                    begin
                        oe_n_reg  <= 1'b1;
                        state_reg <= ST_REG;
                    end
                end
                ST_REG:
                    if (bit_cnt_reg == 4'h8)
                    begin
                        ptr_reg   <= shift_reg;
                        oe_n_reg  <= 1'b0;
                        state_reg <= ST_ACK_REG;
                    end
                ST_WDATA:
                    if (bit_cnt_reg == 4'h8)
                    begin
                        oe_n_reg  <= 1'b0;
                        state_reg <= ST_ACK_W;
                    end
                ST_ACK_REG, ST_ACK_W:
                begin
                    if (state_reg == ST_ACK_W)
                        ptr_reg <= ptr_reg + 8'h01;
                    bit_cnt_reg <= 4'h0;
                    oe_n_reg    <= 1'b1;
                    state_reg   <= ST_WDATA;
                end
                ST_RDATA:
                    if (bit_cnt_reg == 4'h7)
                    begin
                        oe_n_reg  <= 1'b1;
                        state_reg <= ST_RACK;
                    end
                    else
                    begin
                        oe_n_reg    <= tx_reg[6];
                        tx_reg      <= {tx_reg[6:0], 1'b1};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                ST_RACK:
                    if (ack_ok_reg)
                    begin
                        ptr_reg     <= ptr_reg + 8'h01;
                        tx_reg      <= rd_byte(ptr_reg + 8'h01);
                        oe_n_reg    <= rd_byte(ptr_reg + 8'h01) >> 7 == 8'h01 ? 1'b1 : 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= ST_RDATA;
                    end
                    else
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
    assign sda_o    = 1'b0;   // open drain: only ever pulls low
    assign sda_oe_n = oe_n_reg;

    // a data byte completes on the falling edge after its eighth bit
    assign wr_hit = scl_fall & ~start_cond & ~stop_cond
                  & (state_reg == ST_WDATA) & (bit_cnt_reg == 4'h8);

    // writable config bytes; status offsets simply have no write path
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            limit_cfg_reg <= LIMIT_CFG_RST;
            freq_cfg_reg  <= FREQ_CFG_RST;
        end
        else if (wr_hit)
        begin
            if (ptr_reg == ADDR_LIMIT_CFG)
                limit_cfg_reg <= shift_reg[4:0];
            if (ptr_reg == ADDR_FREQ_CFG)
                freq_cfg_reg <= shift_reg[4:0];
        end
    end

    // frequency strap read once, after the sync pipe has filled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_cnt_reg    <= 2'b00;
            cap_done_reg   <= 1'b0;
            freq_strap_reg <= FREQ_STRAP_RST;
        end
        else if (!cap_done_reg)
        begin
            if (cap_cnt_reg == STRAP_SETTLE_CYC)
            begin
                cap_done_reg   <= 1'b1;
                freq_strap_reg <= {freq_strap_s[4:1], 1'b0};
            end
            else
                cap_cnt_reg <= cap_cnt_reg + 2'b01;
        end
    end

    // both latch bytes must agree before the programmed value takes over
    assign limit_sel = sel_latch_a[SEL_LIMIT_BIT] & sel_latch_b[SEL_LIMIT_BIT];
    assign freq_sel  = sel_latch_a[SEL_FREQ_BIT] & sel_latch_b[SEL_FREQ_BIT];
    assign limit_code_next = limit_sel ? limit_cfg_reg : limit_strap_s;
    assign freq_code_next  = freq_sel ? freq_cfg_reg : freq_strap_reg;

    // active codes and threshold voltage, registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            limit_code_active <= LIMIT_CFG_RST;
            freq_code_active  <= FREQ_STRAP_RST;
            limit_thresh_mv   <= 11'(LIMIT_BASE_MV);
        end
        else
        begin
            limit_code_active <= limit_code_next;
            freq_code_active  <= freq_code_next;
            limit_thresh_mv   <=
                11'(LIMIT_BASE_MV + LIMIT_STEP_MV * int'(limit_code_next));
        end
    end

    // frequency lookup one cycle behind the active code
    plf_freq_table u_freq_table
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .code    (freq_code_active),
        .phases  (phases_s),
        .khz_reg (freq_khz)
    );
endmodule

//--- plf_regs_sva.sv
/*
 * assertions on the slice's ports.
 * assumes straps steady after reset.
 */
`timescale 1ns/1ps
module plf_regs_sva
    import plf_pkg::*;
(
    input wire logic                            clk, // clock
    input wire logic                            rstn, // reset
    input wire logic                            scl_i, // scl
    input wire logic                            sda_i, // sda in
    input wire logic                            sda_o, // sda out
    input wire logic                            sda_oe_n, // pull, low
    input wire logic [plf_pkg::CODE_W-1:0]      limit_strap_code, // strap
    input wire logic [plf_pkg::CODE_W-1:0]      freq_strap_code, // strap
    input wire logic [plf_pkg::PHASES-1:0]      phase_limit_hit, // flags
    input wire logic [plf_pkg::PHASE_CNT_W-1:0] active_phases, // phases
    input wire logic [7:0]                      sel_latch_a, // latch a
    input wire logic [7:0]                      sel_latch_b, // latch b
    input wire logic [plf_pkg::CODE_W-1:0]      limit_code_active, // in force
    input wire logic [plf_pkg::MV_W-1:0]        limit_thresh_mv, // mV
    input wire logic [plf_pkg::CODE_W-1:0]      freq_code_active, // in force
    input wire logic [plf_pkg::KHZ_W-1:0]       freq_khz // kHz
);
    logic       sel_l;
    logic       sel_f;
    logic [3:0] age_reg;

    // both latches must agree
    assign sel_l = sel_latch_a[SEL_LIMIT_BIT] & sel_latch_b[SEL_LIMIT_BIT];
    assign sel_f = sel_latch_a[SEL_FREQ_BIT] & sel_latch_b[SEL_FREQ_BIT];

    // cycles since release, saturating
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            age_reg <= 4'h0;
        else if (age_reg != 4'hf)
            age_reg <= age_reg + 4'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_LIMIT_STRAP: assert property (
        (!sel_l && $stable(limit_strap_code))[*8] |-> limit_code_active == limit_strap_code
    ) else $error("limit code not following strap");
    AST_LIMIT_ONE_LATCH: assert property (
        ((sel_latch_a[SEL_LIMIT_BIT] ^ sel_latch_b[SEL_LIMIT_BIT])
         && $stable(limit_strap_code))[*8]
        |-> limit_code_active == limit_strap_code
    ) else $error("single latch changed limit source");
    AST_LIMIT_MV: assert property (
        limit_thresh_mv == MV_W'(LIMIT_BASE_MV + LIMIT_STEP_MV * limit_code_active)
    ) else $error("threshold mV does not match code");
    AST_FREQ_EVEN: assert property (
        (!sel_f)[*2] |-> freq_code_active[0] == 1'b0
    ) else $error("odd strap frequency code");
    AST_FREQ_ONCE: assert property (
        (age_reg == 4'hf && !sel_f)[*3] |-> $stable(freq_code_active)
    ) else $error("strap frequency code changed after capture");
    AST_COLD_FREQ: assert property (
        (age_reg == 4'hc && !sel_f) |-> freq_code_active == {freq_strap_code[4:1], 1'b0}
    ) else $error("cold start frequency not from strap");
    AST_KHZ_LOW: assert property (
        (age_reg == 4'hf && active_phases == 4'h8 && freq_code_active == 5'h00)[*4]
        |=> freq_khz == 13'd221
    ) else $error("lowest code frequency wrong");
    AST_KHZ_HIGH: assert property (
        (age_reg == 4'hf && active_phases == 4'h8 && freq_code_active == 5'h1f)[*4]
        |=> freq_khz == 13'd1312
    ) else $error("highest code frequency wrong");

    cover property (sel_l [*4]);
    cover property (sel_f && freq_code_active == 5'h1f);
    cover property (!sda_oe_n);
endmodule

bind plf_regs plf_regs_sva u_sva (.clk, .rstn, .scl_i, .sda_i, .sda_o, .sda_oe_n,
    .limit_strap_code, .freq_strap_code, .phase_limit_hit, .active_phases, .sel_latch_a,
    .sel_latch_b, .limit_code_active, .limit_thresh_mv, .freq_code_active, .freq_khz);

//--- plf_host.sv
/*
 * two-wire host model: register writes and reads.
 * assumes a pulled-up data wire.
 */
`timescale 1ns/1ps
module plf_host
(
    input  wire logic       clk,      // system clock
    input  wire logic       sda_line, // resolved data wire
    output logic            scl,      // serial clock, still between frames
    output logic            sda,      // 0 pulls low, 1 releases
    output logic            rd_valid, // one-cycle read strobe
    output logic [7:0]      rd_data   // byte read back
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    // quarter bit: 4 cycles keeps each clock phase well above 20 ns
    task automatic q();
        repeat (4) @(posedge clk);
    endtask

    // data set a quarter before scl rises, read mid-high
    task automatic bit_io(input logic b, output logic r);
        sda <= b;
        q();
        scl <= 1'b1;
        q();
        r = sda_line;
        q();
        scl <= 1'b0;
        q();
    endtask

    task automatic start();
        sda <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask

    task automatic stop();
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b1;
        q();
    endtask

    // msb first; ninth bit b9 out, nk back
    task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                        output logic nk);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(b9, nk);
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                      output logic nk);
        logic [7:0] rx;
        logic       n0;
        logic       n1;
        logic       n2;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, n0);
        xfer(ofs, 1'b1, rx, n1);
        xfer(d, 1'b1, rx, n2);
        stop();
        nk = n0 | n1 | n2;
    endtask

    // one-byte read ended by a nack
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs);
        logic [7:0] rx;
        logic       n;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, n);
        xfer(ofs, 1'b1, rx, n);
        start();
        xfer({dev, 1'b1}, 1'b1, rx, n);
        xfer(8'hff, 1'b1, rx, n);
        stop();
        rd_data <= rx;
        rd_valid <= 1'b1;
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask
endmodule

//--- test_phase_limit_and_freq_regs.sv
/*
 * self-checking bench for the limit / frequency slice.
 * assumes the host model and a pulled-up wire.
 */
`timescale 1ns/1ps
module test_phase_limit_and_freq_regs;
    import plf_pkg::*;
    localparam logic [6:0] DA = DEV_ADDR_DEFAULT;
    logic        clk, rstn, scl, sda_host, sda_line, sda_o, sda_oe_n, rd_valid, nk;
    logic [7:0]  rd_data, sel_a, sel_b, hit;
    logic [4:0]  lim_strap, frq_strap, frq_cap, lim_act, frq_act, cfg;
    logic [3:0]  phases;
    logic [10:0] mv;
    logic [12:0] khz;
    logic [21:0] tbl [5];
    logic [7:0]  expq [$];
    int          failures, checked, cycles, seed;

    // open-drain wire with pull-up
    assign sda_line = sda_host & (sda_oe_n | sda_o);

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    plf_regs DUT (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .limit_strap_code(lim_strap), .freq_strap_code(frq_strap),
        .phase_limit_hit(hit), .active_phases(phases), .sel_latch_a(sel_a),
        .sel_latch_b(sel_b), .limit_code_active(lim_act), .limit_thresh_mv(mv),
        .freq_code_active(frq_act), .freq_khz(khz));
    plf_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_host),
        .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic tally_and_finish();
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp({8'h00, got}, {8'h00, exp});
    endtask

    // queue the note, then fetch
    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        expq.push_back(exp);
        host.rd(DA, ofs);
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    // judge each read against the oldest note
    always @(posedge clk)
    begin
        if (rd_valid === 1'b1)
            cmp_byte(rd_data, expq.pop_front());
    end

    // hang guard, run needs ~16k cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        seed = 32'hf7f17382;
        failures = 0;
        checked = 0;
        cycles = 0;
        rstn = 1'b0;
        sel_a = 8'h00;
        sel_b = 8'h00;
        phases = 4'h8;
        hit = 8'($random(seed));
        lim_strap = 5'($random(seed));
        frq_strap = 5'($random(seed));
        frq_cap = frq_strap & 5'h1e;
        tbl = '{{5'h1f, 4'h8, 13'd1312}, {5'h00, 4'h8, 13'd221}, {5'h01, 4'h8, 13'd244},
                {5'h1f, 4'h1, 13'd1330}, {5'h10, 4'h3, 13'd789}};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (20) @(posedge clk);
        // cold start: strap settings govern
        cmp(16'(lim_act), 16'(lim_strap));
        cmp(16'(frq_act), 16'(frq_cap));
        rd_chk(ADDR_FREQ_STRAP, {3'b000, frq_cap});
        rd_chk(ADDR_LIMIT_FLAGS, hit);
        rd_chk(ADDR_LIMIT_CFG, {3'b000, lim_strap});
        // status bytes ignore writes; flags live; strap not re-read
        host.wr(DA, ADDR_LIMIT_FLAGS, ~hit, nk);
        cmp(16'(nk), 16'h0000);
        host.wr(DA, ADDR_FREQ_STRAP, ~{3'b000, frq_cap}, nk);
        hit <= 8'h80;
        frq_strap <= ~frq_strap;
        settle();
        rd_chk(ADDR_LIMIT_FLAGS, 8'h80);
        hit <= 8'h01;
        rd_chk(ADDR_LIMIT_FLAGS, 8'h01);
        rd_chk(ADDR_FREQ_STRAP, {3'b000, frq_cap});
        // threshold codes at both ends, code 1 and one random; top bits junk
        for (int i = 0; i < 4; i++)
        begin
            cfg = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h1f : 5'($random(seed));
            host.wr(DA, ADDR_LIMIT_CFG, {3'b111, cfg}, nk);
            settle();
            cmp(16'(lim_act), 16'(lim_strap));
            sel_a <= 8'h04;
            settle();
            cmp(16'(lim_act), 16'(lim_strap));
            sel_b <= 8'h04;
            settle();
            cmp(16'(lim_act), 16'(cfg));
            cmp(16'(mv), 16'(LIMIT_BASE_MV + LIMIT_STEP_MV * cfg));
            rd_chk(ADDR_LIMIT_CFG, {3'b000, cfg});
            sel_a <= 8'h00;
            sel_b <= 8'h00;
        end
        // frequency: written code waits for both latches
        host.wr(DA, ADDR_FREQ_CFG, 8'h1f, nk);
        settle();
        cmp(16'(frq_act), 16'(frq_cap));
        sel_a <= 8'h01;
        sel_b <= 8'h01;
        for (int i = 0; i < 5; i++)
        begin
            phases <= tbl[i][16:13];
            host.wr(DA, ADDR_FREQ_CFG, {3'b000, tbl[i][21:17]}, nk);
            settle();
            cmp(16'(frq_act), 16'(tbl[i][21:17]));
            cmp(16'(khz), 16'(tbl[i][12:0]));
            rd_chk(ADDR_FREQ_CFG, {3'b000, tbl[i][21:17]});
        end
        phases <= 4'h8;
        sel_b <= 8'h00;
        settle();
        cmp(16'(frq_act), 16'(frq_cap));
        // unmapped offset and a foreign device address
        rd_chk(8'h50, 8'h00);
        host.wr(DA ^ 7'h01, ADDR_LIMIT_CFG, 8'h00, nk);
        cmp(16'(nk), 16'h0001);
        settle();
        cmp(16'(expq.size()), 16'h0000);
        tally_and_finish();
    end
endmodule
